/* design/card_host_defs.svh */
// Timing figures and pin layout constants for the memory card host port.
// Assumes a 10 ns system clock; counts are derived from the figures here.
`ifndef CARD_HOST_DEFS_SVH
`define CARD_HOST_DEFS_SVH

`define CLK_PERIOD_NS    10
`define RST_PULSE_NS     200
`define READ_ACCESS_NS   200
`define WRITE_PULSE_NS   100
`define SETUP_NS         10
`define HOLD_NS          40
// Least times round up to whole cycles
`define CEIL_CYCLES(ns)  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CYCLES       `CEIL_CYCLES(`RST_PULSE_NS)
`define READ_CYCLES      `CEIL_CYCLES(`READ_ACCESS_NS)
`define WRITE_CYCLES     `CEIL_CYCLES(`WRITE_PULSE_NS)
`define HOLD_CYCLES      `CEIL_CYCLES(`HOLD_NS)
`define SYNC_LATENCY     3
`define ADDR_W           26
`define DATA_W           16
`define LOW_LANE_OE_N    16'hff00
`define ALL_LANES_OE_N   16'h0000
`define NO_LANES_OE_N    16'hffff

`endif

/* design/card_host_pkg.sv */
// Types shared by the memory card host port.
// Assumes card_host_defs.svh is on the include path.
`include "card_host_defs.svh"

package card_host_pkg;

	typedef struct packed {
		logic                 write;
		logic                 reg_space;
		logic                 byte_mode;
		logic [`ADDR_W-1:0]   addr;
		logic [`DATA_W-1:0]   wdata;
	} req_t;

	typedef struct packed {
		logic [`ADDR_W-1:0]   addr;
		logic                 even_n;
		logic                 odd_n;
		logic                 oe_n;
		logic                 we_n;
		logic                 reg_n;
		logic                 rst;
		logic [`DATA_W-1:0]   dout;
		logic [`DATA_W-1:0]   dout_oe_n;
	} pins_t;

	typedef enum logic [2:0] {
		ST_RESET  = 3'b000,
		ST_IDLE   = 3'b001,
		ST_ARM    = 3'b010,
		ST_SETUP  = 3'b011,
		ST_STROBE = 3'b100,
		ST_HOLD   = 3'b101
	} state_t;

endpackage

/* design/card_sync.sv */
// Three-stage synchroniser for card pins sampled on the system clock.
// Assumes inputs are asynchronous; a bit changes once stages two and three agree.
`timescale 1ns/1ns

module card_sync #(
	parameter int WIDTH = 19
) (
	input  wire logic             clk_in,
	input  wire logic             srst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] stable_out
);

	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
	logic [WIDTH-1:0] out_next;

	////////////////////////////////////////////////////////////////////////
	// Stage one feeds stage two only; filtering looks at two and three
	always_comb begin
		out_next = out_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				out_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			out_reg <= '0;
		end else begin
			s1_reg  <= async_in;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign stable_out = out_reg;

endmodule

/* design/card_host.sv */
// Host socket controller driving a 68-pin parallel flash memory card.
// Assumes a user-side request port on clk_in; card pins are asynchronous.
`timescale 1ns/1ns
`include "card_host_defs.svh"

// Functional notes
// - The host still drives address bit 25 although the card leaves it unconnected.
// - The even enable selects even bytes and the odd enable odd bytes; with bit 0 a byte host reaches all bytes.
// - The host lowers output enable to request read data and the card drives only while it is low.
// - The host lowers write enable to present write data, which the card captures under the strobe.
// - A high reset pulse of at least 200 ns returns the card to its power-on state.
module card_host #(
	parameter int RST_CYCLES   = `RST_CYCLES,
	parameter int READ_CYCLES  = `READ_CYCLES,
	parameter int WRITE_CYCLES = `WRITE_CYCLES,
	parameter int HOLD_CYCLES  = `HOLD_CYCLES
) (
	input  wire logic                clk_in,
	input  wire logic                srst_in,
	input  wire card_host_pkg::req_t req_in,
	input  wire logic                req_valid_in,
	output logic                     req_ready_out,
	input  wire logic                card_reset_req_in,
	output logic                     rsp_valid_out,
	output logic                     rsp_err_out,
	output logic [`DATA_W-1:0]       rsp_data_out,
	output logic [`ADDR_W-1:0]       address_bus_out,
	output logic                     even_byte_enable_n_out,
	output logic                     odd_byte_enable_n_out,
	output logic                     oe_n_out,
	output logic                     we_n_out,
	output logic                     reg_select_n_out,
	output logic                     card_reset_out,
	output logic [`DATA_W-1:0]       data_bus_out,
	output logic [`DATA_W-1:0]       data_bus_oe_n_out,
	input  wire logic [`DATA_W-1:0]  data_bus_in,
	input  wire logic                ready_busy_in,
	input  wire logic                write_protect_in,
	input  wire logic                wait_n_in,
	output logic                     card_ready_out,
	output logic                     write_protected_out
);

	// Counters are eight bits wide; refuse counts they cannot hold
	if (RST_CYCLES < 1 || READ_CYCLES < 1 || WRITE_CYCLES < 1 || HOLD_CYCLES < 1 ||
	    RST_CYCLES > 255 || READ_CYCLES + `SYNC_LATENCY > 255 || WRITE_CYCLES > 255 ||
	    HOLD_CYCLES + `SYNC_LATENCY > 255) begin : g_bad_counts
		$error("card_host: cycle counts out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	logic [`DATA_W-1:0] din_sync;
	logic               rb_sync, wp_sync, wait_n_sync;

	card_sync #(.WIDTH(`DATA_W + 3)) u_sync (
		.clk_in     (clk_in),
		.srst_in    (srst_in),
		.async_in   ({data_bus_in, ready_busy_in, write_protect_in, wait_n_in}),
		.stable_out ({din_sync, rb_sync, wp_sync, wait_n_sync})
	);

	////////////////////////////////////////////////////////////////////////
	// Pin images
	function automatic card_host_pkg::pins_t idle_pins(input logic rst);
		card_host_pkg::pins_t p;
		p           = '0;
		p.even_n    = 1'b1;
		p.odd_n     = 1'b1;
		p.oe_n      = 1'b1;
		p.we_n      = 1'b1;
		p.reg_n     = 1'b1;
		p.rst       = rst;
		p.dout_oe_n = `NO_LANES_OE_N;
		return p;
	endfunction

	function automatic card_host_pkg::pins_t access_pins(input card_host_pkg::req_t r);
		card_host_pkg::pins_t p;
		p        = idle_pins(1'b0);
		p.addr   = r.addr;
		p.even_n = 1'b0;
		p.odd_n  = r.byte_mode;
		p.reg_n  = ~r.reg_space;
		if (!r.byte_mode) begin
			p.addr[0] = 1'b0;
		end
		if (r.write) begin
			p.dout      = r.byte_mode ? {8'h00, r.wdata[7:0]} : r.wdata;
			p.dout_oe_n = r.byte_mode ? `LOW_LANE_OE_N : `ALL_LANES_OE_N;
		end
		return p;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Access sequencer
	card_host_pkg::state_t state_reg, state_next;
	card_host_pkg::pins_t  pins_reg, pins_next;
	card_host_pkg::req_t   req_reg, req_next;
	logic [7:0]            cnt_reg, cnt_next;
	logic                  ready_reg, ready_next;
	logic                  rsp_valid_reg, rsp_valid_next;
	logic                  rsp_err_reg, rsp_err_next;
	logic [`DATA_W-1:0]    rsp_data_reg, rsp_data_next;
	logic                  accept;

	assign accept = req_valid_in && ready_reg;

	always_comb begin
		state_next     = state_reg;
		pins_next      = pins_reg;
		req_next       = req_reg;
		cnt_next       = cnt_reg;
		rsp_valid_next = 1'b0;
		rsp_err_next   = rsp_err_reg;
		rsp_data_next  = rsp_data_reg;
		unique case (state_reg)
			card_host_pkg::ST_RESET: begin
				pins_next = idle_pins(1'b1);
				if (cnt_reg >= 8'(RST_CYCLES - 1)) begin
					pins_next  = idle_pins(1'b0);
					state_next = card_host_pkg::ST_IDLE;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
			card_host_pkg::ST_IDLE: begin
				cnt_next = 8'h00;
				if (card_reset_req_in) begin
					// Raise reset at once so the pulse spans the full count
					pins_next  = idle_pins(1'b1);
					state_next = card_host_pkg::ST_RESET;
				end else if (accept) begin
					req_next = req_in;
					if (req_in.write && wp_sync) begin
						// Card would drop the write silently; report it instead
						rsp_valid_next = 1'b1;
						rsp_err_next   = 1'b1;
						rsp_data_next  = '0;
					end else begin
						state_next = card_host_pkg::ST_ARM;
					end
				end
			end
			card_host_pkg::ST_ARM: begin
				if (rb_sync) begin
					pins_next  = access_pins(req_reg);
					state_next = card_host_pkg::ST_SETUP;
				end
			end
			card_host_pkg::ST_SETUP: begin
				pins_next.oe_n = req_reg.write;
				pins_next.we_n = ~req_reg.write;
				cnt_next       = req_reg.write ? 8'(WRITE_CYCLES - 1) : 8'(READ_CYCLES + `SYNC_LATENCY - 1);
				state_next     = card_host_pkg::ST_STROBE;
			end
			card_host_pkg::ST_STROBE: begin
				if (cnt_reg != 8'h00) begin
					cnt_next = cnt_reg - 8'h01;
				end else if (wait_n_sync) begin
					pins_next.oe_n = 1'b1;
					pins_next.we_n = 1'b1;
					rsp_err_next   = 1'b0;
					rsp_data_next  = req_reg.write ? '0 :
					                 (req_reg.byte_mode ? {8'h00, din_sync[7:0]} : din_sync);
					// Hold long enough for a fresh busy level to reach rb_sync
					cnt_next       = 8'(HOLD_CYCLES + `SYNC_LATENCY - 1);
					state_next     = card_host_pkg::ST_HOLD;
				end
			end
			card_host_pkg::ST_HOLD: begin
				if (cnt_reg != 8'h00) begin
					cnt_next = cnt_reg - 8'h01;
				end else begin
					pins_next      = idle_pins(1'b0);
					rsp_valid_next = 1'b1;
					state_next     = card_host_pkg::ST_IDLE;
				end
			end
		endcase
		if (state_next == card_host_pkg::ST_RESET && state_reg != card_host_pkg::ST_RESET) begin
			cnt_next = 8'h00;
		end
		ready_next = (state_next == card_host_pkg::ST_IDLE) && !rsp_valid_next;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_reg     <= card_host_pkg::ST_RESET;
			pins_reg      <= idle_pins(1'b1);
			req_reg       <= '0;
			cnt_reg       <= 8'h00;
			ready_reg     <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_err_reg   <= 1'b0;
			rsp_data_reg  <= '0;
		end else begin
			state_reg     <= state_next;
			pins_reg      <= pins_next;
			req_reg       <= req_next;
			cnt_reg       <= cnt_next;
			ready_reg     <= ready_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_err_reg   <= rsp_err_next;
			rsp_data_reg  <= rsp_data_next;
		end
	end

	assign req_ready_out          = ready_reg;
	assign rsp_valid_out          = rsp_valid_reg;
	assign rsp_err_out            = rsp_err_reg;
	assign rsp_data_out           = rsp_data_reg;
	assign address_bus_out        = pins_reg.addr;
	assign even_byte_enable_n_out = pins_reg.even_n;
	assign odd_byte_enable_n_out  = pins_reg.odd_n;
	assign oe_n_out               = pins_reg.oe_n;
	assign we_n_out               = pins_reg.we_n;
	assign reg_select_n_out       = pins_reg.reg_n;
	assign card_reset_out         = pins_reg.rst;
	assign data_bus_out           = pins_reg.dout;
	assign data_bus_oe_n_out      = pins_reg.dout_oe_n;
	// Alternate ready-busy meanings are set up by software through the attribute plane
	assign card_ready_out         = rb_sync;
	assign write_protected_out    = wp_sync;

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [7:0] rst_len_reg, rst_len_next;

	always_comb begin
		rst_len_next = pins_reg.rst ? ((rst_len_reg == 8'hff) ? rst_len_reg : rst_len_reg + 8'h01) : 8'h00;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rst_len_reg <= 8'h00;
		end else begin
			rst_len_reg <= rst_len_next;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	strobes_exclusive_a: assert property (!(!oe_n_out && !we_n_out)) else $error("oe and we low together");
	read_no_drive_a: assert property (!oe_n_out |-> data_bus_oe_n_out == `NO_LANES_OE_N)
		else $error("host drives data during read");
	write_drive_a: assert property (!we_n_out |-> (data_bus_oe_n_out[7:0] == 8'h00) && $stable(data_bus_out))
		else $error("write data not driven steadily");
	word_low_bit_a: assert property (!even_byte_enable_n_out && !odd_byte_enable_n_out |-> !address_bus_out[0])
		else $error("word access with address bit 0 high");
	byte_lane_a: assert property (even_byte_enable_n_out ^ odd_byte_enable_n_out |-> data_bus_oe_n_out[15:8] == 8'hff)
		else $error("byte access drives high lane");
	reset_width_a: assert property ($fell(card_reset_out) |-> rst_len_reg >= 8'(RST_CYCLES))
		else $error("card reset pulse too short");
	wp_refuse_a: assert property (accept && req_in.write && wp_sync && !card_reset_req_in |=>
		rsp_valid_out && rsp_err_out && we_n_out) else $error("protected write not refused");
	busy_gate_a: assert property (state_reg == card_host_pkg::ST_ARM && !rb_sync |=> even_byte_enable_n_out)
		else $error("access started while card busy");

	read_done_c: cover property (rsp_valid_out && !rsp_err_out && !req_reg.write);
	write_done_c: cover property (rsp_valid_out && !rsp_err_out && req_reg.write);
	wp_refused_c: cover property (rsp_valid_out && rsp_err_out);
	odd_byte_c: cover property (!oe_n_out && odd_byte_enable_n_out && address_bus_out[0]);

endmodule

/* verification/card_model.sv */
// Behavioural flash card on the far side of the host port.
// Assumes the bench ties every host pin to it and runs it from the host clock.
`timescale 1ns/1ns

module card_model #(
	parameter int BUSY_CYCLES = 30
) (
	input  wire logic        clk_in,
	input  wire logic [25:0] address_bus_in,
	input  wire logic        even_n_in,
	input  wire logic        odd_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        we_n_in,
	input  wire logic        reg_n_in,
	input  wire logic        card_reset_in,
	input  wire logic [15:0] host_data_in,
	input  wire logic [15:0] host_oe_n_in,
	input  wire logic        wp_switch_in,
	output logic      [15:0] data_bus_out,
	output logic             ready_busy_out,
	output logic             write_protect_out,
	output logic             wait_n_out
);
	logic [15:0] mem [int];
	logic [15:0] word, drv, en, wr;
	logic [15:0] last = 16'h0000;
	int          busy = 0;
	int          key;
	////////////////////////////////////////////////////////////////
	// Bit 24 is the top decoded bit; bit 0 only picks a byte
	always @* key = int'({reg_n_in, address_bus_in[24:1]});
	always @* begin
		word = mem.exists(key) ? mem[key] : 16'h0000;
		en = 16'h0000;
		drv = word;
		if (!oe_n_in && !card_reset_in) begin
			if (!even_n_in && odd_n_in) begin
				en = 16'h00ff;
				drv[7:0] = address_bus_in[0] ? word[15:8] : word[7:0];
			end else if (!even_n_in) begin
				en = 16'hffff;
			end else if (!odd_n_in) begin
				en = 16'hff00;
			end
		end
		// No pull on the bus: a released bit shows the inverse of its last level
		for (int i = 0; i < 16; i++) begin
			data_bus_out[i] = !host_oe_n_in[i] ? host_data_in[i] : en[i] ? drv[i] : ~last[i];
		end
	end
	////////////////////////////////////////////////////////////////
	always @(posedge we_n_in) begin
		// The first reset edge lifts the strobe out of unknown with no lane enabled
		if (!wp_switch_in && !card_reset_in && (!even_n_in || !odd_n_in)) begin
			wr = mem.exists(key) ? mem[key] : 16'h0000;
			if (!even_n_in && odd_n_in) begin
				if (address_bus_in[0]) wr[15:8] = data_bus_out[7:0];
				else wr[7:0] = data_bus_out[7:0];
			end else begin
				if (!even_n_in) wr[7:0] = data_bus_out[7:0];
				if (!odd_n_in) wr[15:8] = data_bus_out[15:8];
			end
			mem[key] = wr;
			busy = BUSY_CYCLES;
		end
	end
	always @(posedge clk_in) begin
		last <= data_bus_out;
		if (card_reset_in) busy = 0;
		else if (busy > 0) busy = busy - 1;
	end
	assign ready_busy_out = (busy == 0);
	assign write_protect_out = wp_switch_in;
	assign wait_n_out = 1'b1;
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the card host port against a behavioural card.
// Assumes card_host_defs.svh and card_host_pkg are compiled first.
`timescale 1ns/1ns

module tb_top;
	logic clk_in = 1'b0, srst_in = 1'b1, req_valid = 1'b0, crr = 1'b0, wp = 1'b0;
	card_host_pkg::req_t req = '0;
	logic req_ready, rsp_valid, rsp_err, even_n, odd_n, oe_n, we_n, reg_n, card_rst;
	logic rdy_busy, wprot, wait_n, card_ready, wprot_out;
	logic [15:0] rsp_data, dout, dout_oe_n, din, ref_mem [int];
	logic [25:0] addr, s_addr;
	logic [1:0]  s_en;
	logic        p_oe = 1'b1, p_we = 1'b1;
	int err_total = 0, n_tests = 0, we_falls = 0, rst_run = 0, rst_len = 0;

	card_host dut (.clk_in(clk_in), .srst_in(srst_in), .req_in(req), .req_valid_in(req_valid),
		.req_ready_out(req_ready), .card_reset_req_in(crr), .rsp_valid_out(rsp_valid),
		.rsp_err_out(rsp_err), .rsp_data_out(rsp_data), .address_bus_out(addr),
		.even_byte_enable_n_out(even_n), .odd_byte_enable_n_out(odd_n), .oe_n_out(oe_n),
		.we_n_out(we_n), .reg_select_n_out(reg_n), .card_reset_out(card_rst), .data_bus_out(dout),
		.data_bus_oe_n_out(dout_oe_n), .data_bus_in(din), .ready_busy_in(rdy_busy),
		.write_protect_in(wprot), .wait_n_in(wait_n), .card_ready_out(card_ready),
		.write_protected_out(wprot_out));
	card_model card (.clk_in(clk_in), .address_bus_in(addr), .even_n_in(even_n), .odd_n_in(odd_n),
		.oe_n_in(oe_n), .we_n_in(we_n), .reg_n_in(reg_n), .card_reset_in(card_rst),
		.host_data_in(dout), .host_oe_n_in(dout_oe_n), .wp_switch_in(wp), .data_bus_out(din),
		.ready_busy_out(rdy_busy), .write_protect_out(wprot), .wait_n_out(wait_n));

	initial forever #5 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Pin monitor: strobes, bus ownership, strobe address, reset pulse length
	always @(negedge clk_in) begin
		if (!srst_in) begin
			if (!oe_n && !we_n) chk(1, 0, "both strobes low");
			if (!oe_n && dout_oe_n !== 16'hffff) chk(1, 0, "host drives during read");
			if ((!oe_n && p_oe) || (!we_n && p_we)) chk(rdy_busy, 1, "strobe while busy");
			if (!we_n && p_we) we_falls++;
			if (!oe_n || !we_n) begin
				s_addr = addr;
				s_en = {even_n, odd_n};
			end
		end
		p_oe = oe_n;
		p_we = we_n;
		if (card_rst) rst_run++;
		else if (rst_run > 0) begin
			rst_len = rst_run;
			rst_run = 0;
		end
	end
	task automatic do_op(input logic wr, rg, bm, input logic [25:0] a, input logic [15:0] wd);
		int n, k;
		logic [15:0] e, w;
		k = int'({~rg, a[24:1]});
		w = ref_mem.exists(k) ? ref_mem[k] : 16'h0000;
		e = bm ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w;
		n = 0;
		while (req_ready !== 1'b1 && n < 3000) begin
			@(negedge clk_in);
			n++;
		end
		req = '{write: wr, reg_space: rg, byte_mode: bm, addr: a, wdata: wd};
		req_valid = 1'b1;
		@(negedge clk_in);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 3000) begin
			@(negedge clk_in);
			n++;
		end
		chk(rsp_valid, 1, "no response");
		chk(rsp_err, wr & wp, "error flag");
		chk(rsp_data, wr ? 16'h0000 : e, "read data");
		if (!(wr && wp)) begin
			chk(s_addr, {a[25:1], bm & a[0]}, "strobe address");
			chk(s_en, bm ? 2'b01 : 2'b00, "lane enables");
		end
		if (wr && !wp) begin
			if (bm && a[0]) w[15:8] = wd[7:0];
			else if (bm) w[7:0] = wd[7:0];
			else w = wd;
			ref_mem[k] = w;
			chk(card_ready, 0, "card busy after write");
		end
		@(negedge clk_in);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		err_total++;
		print_verdict();
	end
	initial begin
		logic [31:0] r;
		r = $urandom(32'h01a6);
		repeat (2) @(negedge clk_in);
		srst_in = 1'b0;
		do_op(1, 0, 0, 26'h3000003, 16'ha55a);
		do_op(0, 0, 0, 26'h1000002, 16'h0000);
		do_op(0, 0, 1, 26'h1000003, 16'h0000);
		chk(rst_len >= 20, 1, "power-on card reset width");
		$display("test word and byte basics done");
		do_op(1, 0, 1, 26'h0000011, 16'h0077);
		do_op(1, 0, 1, 26'h0000010, 16'h0044);
		do_op(0, 0, 0, 26'h0000010, 16'h0000);
		do_op(1, 1, 0, 26'h0000010, 16'hbeef);
		do_op(0, 0, 0, 26'h0000010, 16'h0000);
		do_op(0, 1, 1, 26'h0000011, 16'h0000);
		$display("test lanes and planes done");
		for (int i = 0; i < 24; i++) begin
			r = $urandom;
			do_op(r[0], r[1], r[2], {r[4:3], 19'h00000, r[9:5]}, r[31:16]);
		end
		$display("test random traffic done");
		wp = 1'b1;
		repeat (6) @(negedge clk_in);
		chk(wprot_out, 1, "protect level");
		n_tests++;
		r = we_falls;
		do_op(1, 0, 0, 26'h0000010, 16'h1234);
		chk(we_falls, r, "write strobe while protected");
		wp = 1'b0;
		do_op(0, 0, 0, 26'h0000010, 16'h0000);
		$display("test write protect done");
		while (req_ready !== 1'b1) @(negedge clk_in);
		crr = 1'b1;
		@(negedge clk_in);
		crr = 1'b0;
		repeat (30) begin
			@(negedge clk_in);
			chk(rsp_valid, 0, "response on card reset");
		end
		chk(rst_len, 20, "card reset width");
		do_op(0, 0, 1, 26'h0000011, 16'h0000);
		$display("test card reset done");
		print_verdict();
	end
endmodule
